// ---- logic/ivs_vector_stack.v ----
// Behaviour
// - flags register A shows pending sources 14..8 on bits 7..1, bit 0 (source 7) always zero, read-only, resets zero
// - flags register B shows source 16 on bit 1, 15 on bit 0, rest zero
// - conversion-done source 15 vectors through FFDE high, FFDF low
// - serial tx, rx, error sources 13..11 vector at FFE2, FFE4, FFE6
// - spi tx source 10 and rx source 9 vector at FFE8, FFEA
// - timer b overflow at FFEC; source 7 pair FFEE reserved, never granted
// - timer b channel 0 source 6 vectors through FFF0
// - timer a overflow source 5 vectors through FFF2
// - timer a channel 1 and 0, sources 4 and 3, vector at FFF4, FFF6
// - interrupt entry pushes five bytes of register state
// - index high register is not part of the interrupt frame
// - subroutine call pushes a two-byte return address
// - stack pointer decrements per push, increments per pull
// - stack pointer is 16 bits wide
// - stack pointer resets to 00FF
`timescale 1ns/100ps
`default_nettype none
`include "ivs_defs.vh"

module ivs_vector_stack (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [15:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// peripheral pending levels, bit n = source n (bit 0 unused)
	input wire [16:0] src_pending,
	// software interrupt and reset vector requests from the core
	input wire soft_int_req,
	input wire reset_vec_req,
	// core stack operations, one-cycle pulses
	input wire irq_entry,
	input wire sub_call,
	input wire push_byte,
	input wire pull_byte,
	// reset vector low byte as held in memory
	input wire [7:0] reset_vec_low,
	// vector fetch result
	output reg vec_valid,
	output reg [15:0] vec_addr,
	output reg [4:0] vec_src,
	// stack pointer and frame bookkeeping
	output reg [15:0] stack_ptr,
	output reg [2:0] frame_left,
	// watchdog clear strobe
	output reg wdog_clear,
	// interrupt line
	output reg irq
);

	// ***************************************************
	// helpers
	// ***************************************************
	// high-byte address of a numbered source; unused numbers fall to the bottom pair
	function [15:0] vec_of;
		input [4:0] src;
		begin
			case (src)
				5'h01: vec_of = `IVS_VEC_EXT_PIN;
				5'h02: vec_of = `IVS_VEC_PLL;
				5'h03: vec_of = `IVS_VEC_TA_CH0;
				5'h04: vec_of = `IVS_VEC_TA_CH1;
				5'h05: vec_of = `IVS_VEC_TA_OVF;
				5'h06: vec_of = `IVS_VEC_TB_CH0;
				5'h07: vec_of = `IVS_VEC_RSVD;
				5'h08: vec_of = `IVS_VEC_TB_OVF;
				5'h09: vec_of = `IVS_VEC_SPI_RX;
				5'h0A: vec_of = `IVS_VEC_SPI_TX;
				5'h0B: vec_of = `IVS_VEC_SER_ERR;
				5'h0C: vec_of = `IVS_VEC_SER_RX;
				5'h0D: vec_of = `IVS_VEC_SER_TX;
				5'h0E: vec_of = `IVS_VEC_KEYBOARD;
				5'h0F: vec_of = `IVS_VEC_CONV_DONE;
				5'h10: vec_of = `IVS_VEC_TIMEBASE;
				default: vec_of = `IVS_VEC_BASE;
			endcase
		end
	endfunction

	// ***************************************************
	// apb access decode
	// ***************************************************
	wire acc = psel & penable & ~pready;
	wire wr = acc & pwrite;
	wire rd = acc & ~pwrite;

	// ***************************************************
	// register selects
	// ***************************************************
	wire sel_flags_a = (paddr == `IVS_ADDR_FLAGS_A);
	wire sel_flags_b = (paddr == `IVS_ADDR_FLAGS_B);
	wire sel_wdog = (paddr == `IVS_ADDR_WDOG);
	wire sel_status = (paddr == `IVS_ADDR_STATUS);
	wire sel_clear = (paddr == `IVS_ADDR_CLEAR);
	wire sel_enable = (paddr == `IVS_ADDR_ENABLE);
	wire sel_sp = (paddr == `IVS_ADDR_SP);

	reg [7:0] flags_a_q;
	reg [7:0] flags_b_q;
	reg [`IVS_EVT_W-1:0] evt_q;
	reg [`IVS_EVT_W-1:0] en_q;
	reg [7:0] rdata_d;
	reg known_d;

	// ***************************************************
	// pending flag views
	// ***************************************************
	// source 7 masked so the reserved pair never shows as pending
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_a_q <= `IVS_FLAGS_RESET;
		end else begin
			flags_a_q <= {src_pending[14:8], 1'b0};
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_b_q <= `IVS_FLAGS_RESET;
		end else begin
			flags_b_q <= {6'h00, src_pending[16:15]};
		end
	end

	always @* begin
		rdata_d = 8'h00;
		known_d = 1'b1;
		case (paddr)
			`IVS_ADDR_FLAGS_A: rdata_d = flags_a_q;
			`IVS_ADDR_FLAGS_B: rdata_d = flags_b_q;
			`IVS_ADDR_WDOG: rdata_d = reset_vec_low;
			`IVS_ADDR_STATUS: rdata_d = {5'h00, evt_q};
			`IVS_ADDR_ENABLE: rdata_d = {5'h00, en_q};
			`IVS_ADDR_CLEAR: rdata_d = 8'h00;
			`IVS_ADDR_SP: rdata_d = 8'h00;
			default: known_d = 1'b0;
		endcase
	end

	// ***************************************************
	// bus answer: one wait state, ready in the second access cycle
	// ***************************************************
	reg pready_d;
	reg pslverr_d;
	always @* begin
		pready_d = acc;
		pslverr_d = acc & ~known_d;
	end

	// stack pointer is the only 16-bit register; others use the low byte
	reg [31:0] prdata_d;
	always @* begin
		prdata_d = prdata;
		if (rd) begin
			if (sel_sp) begin
				prdata_d = {16'h0000, stack_ptr};
			end else begin
				prdata_d = {24'h000000, rdata_d};
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= pready_d;
			pslverr <= pslverr_d;
			prdata <= prdata_d;
		end
	end

	// writes take effect at the same clock edge where pready rises; flag regs ignore writes
	wire wr_ok = wr & known_d;

	// ***************************************************
	// watchdog clear: any write at FFFF, no storage
	// ***************************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdog_clear <= 1'b0;
		end else begin
			wdog_clear <= wr_ok & sel_wdog;
		end
	end

	// ***************************************************
	// priority select: scan downward, keep the last hit, so the lowest source number and higher vector wins
	// ***************************************************
	reg [4:0] win_d;
	reg hit_d;
	integer i;
	always @* begin
		win_d = 5'h00;
		hit_d = 1'b0;
		for (i = 16; i >= 1; i = i - 1) begin
			if (src_pending[i] && (i != `IVS_RESERVED_SRC)) begin
				win_d = i[4:0];
				hit_d = 1'b1;
			end
		end
	end

	// ***************************************************
	// vector selection
	// ***************************************************
	// reset and software requests outrank every numbered source
	reg [15:0] vec_addr_d;
	reg [4:0] vec_src_d;
	always @* begin
		vec_addr_d = vec_of(win_d);
		vec_src_d = win_d;
		if (reset_vec_req) begin
			vec_addr_d = `IVS_VEC_RESET;
			vec_src_d = 5'h00;
		end else if (soft_int_req) begin
			vec_addr_d = `IVS_VEC_SOFT_INT;
			vec_src_d = 5'h00;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vec_valid <= 1'b0;
			vec_addr <= `IVS_VEC_RESET;
			vec_src <= 5'h00;
		end else begin
			vec_valid <= reset_vec_req | soft_int_req | hit_d;
			vec_addr <= vec_addr_d;
			vec_src <= vec_src_d;
		end
	end

	// ***************************************************
	// stack pointer and frame tracking
	// ***************************************************
	// frame counts bytes the core still owes; H is never part of it
	reg overrun_d;
	always @* begin
		overrun_d = (irq_entry | sub_call) & (frame_left != 3'h0);
	end

	// ***************************************************
	// stack pointer next value
	// ***************************************************
	// a push and a pull in one cycle cancel out
	reg [15:0] sp_d;
	reg [2:0] frame_d;
	always @* begin
		sp_d = stack_ptr;
		if (wr_ok && sel_sp) begin
			sp_d = pwdata[15:0];
		end else if (push_byte && !pull_byte) begin
			sp_d = stack_ptr - 16'h0001;
		end else if (pull_byte && !push_byte) begin
			sp_d = stack_ptr + 16'h0001;
		end
	end

	// ***************************************************
	// frame bookkeeping
	// ***************************************************
	always @* begin
		frame_d = frame_left;
		if (irq_entry) begin
			frame_d = `IVS_FRAME_IRQ;
		end else if (sub_call) begin
			frame_d = `IVS_FRAME_CALL;
		end else if (push_byte && frame_left != 3'h0) begin
			frame_d = frame_left - 3'h1;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stack_ptr <= `IVS_SP_RESET;
			frame_left <= 3'h0;
		end else begin
			stack_ptr <= sp_d;
			frame_left <= frame_d;
		end
	end

	// ***************************************************
	// event status, clear and enable; set wins over clear
	// ***************************************************
	wire [`IVS_EVT_W-1:0] set_w = {overrun_d, irq_entry, wr_ok & sel_wdog};
	wire [`IVS_EVT_W-1:0] clr_w = (wr_ok && sel_clear) ? pwdata[2:0] : 3'h0;

	// clear is write-one, so writing zero never drops a bit
	reg [`IVS_EVT_W-1:0] evt_d;
	reg irq_d;
	always @* begin
		evt_d = (evt_q & ~clr_w) | set_w;
		irq_d = |(evt_d & en_q);
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_q <= 3'h0;
		end else begin
			evt_q <= evt_d;
		end
	end

	// ***************************************************
	// enable register
	// ***************************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q <= 3'h0;
		end else begin
			if (wr_ok && sel_enable) begin
				en_q <= pwdata[2:0];
			end
		end
	end

	// ***************************************************
	// interrupt line
	// ***************************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= irq_d;
		end
	end

endmodule // ivs_vector_stack
`default_nettype wire

// ---- include/ivs_defs.vh ----
`ifndef IVS_DEFS_VH
`define IVS_DEFS_VH

// ***************************************************
// register byte addresses (8-bit map, one word each)
// ***************************************************
`define IVS_ADDR_FLAGS_A 16'hFE05
`define IVS_ADDR_FLAGS_B 16'hFE06
`define IVS_ADDR_WDOG 16'hFFFF
`define IVS_ADDR_STATUS 16'hFE20
`define IVS_ADDR_CLEAR 16'hFE24
`define IVS_ADDR_ENABLE 16'hFE28
`define IVS_ADDR_SP 16'hFE2C

// ***************************************************
// vector area
// ***************************************************
`define IVS_VEC_BASE 16'hFFDC
`define IVS_VEC_TIMEBASE 16'hFFDC
`define IVS_VEC_CONV_DONE 16'hFFDE
`define IVS_VEC_KEYBOARD 16'hFFE0
`define IVS_VEC_SER_TX 16'hFFE2
`define IVS_VEC_SER_RX 16'hFFE4
`define IVS_VEC_SER_ERR 16'hFFE6
`define IVS_VEC_SPI_TX 16'hFFE8
`define IVS_VEC_SPI_RX 16'hFFEA
`define IVS_VEC_TB_OVF 16'hFFEC
`define IVS_VEC_RSVD 16'hFFEE
`define IVS_VEC_TB_CH0 16'hFFF0
`define IVS_VEC_TA_OVF 16'hFFF2
`define IVS_VEC_TA_CH1 16'hFFF4
`define IVS_VEC_TA_CH0 16'hFFF6
`define IVS_VEC_PLL 16'hFFF8
`define IVS_VEC_EXT_PIN 16'hFFFA
`define IVS_VEC_SOFT_INT 16'hFFFC
`define IVS_VEC_RESET 16'hFFFE
`define IVS_RESERVED_SRC 5'h07

// ***************************************************
// reset values and event bits
// ***************************************************
`define IVS_SP_RESET 16'h00FF
`define IVS_FLAGS_RESET 8'h00
`define IVS_EVT_WDOG 0
`define IVS_EVT_ENTRY 1
`define IVS_EVT_OVERRUN 2
`define IVS_EVT_W 3

// ***************************************************
// stack frame sizes
// ***************************************************
`define IVS_FRAME_IRQ 3'h5
`define IVS_FRAME_CALL 3'h2

`endif

// ---- tb/ivs_chk_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****
// port checks
// ****
module ivs_chk (
	// clock, reset, bus
	input wire logic pclk, presetn, psel, penable, pwrite,
	input wire logic [15:0] paddr,
	// core side
	input wire logic soft_int_req, reset_vec_req, irq_entry, sub_call, push_byte, pull_byte,
	// results
	input wire logic vec_valid, wdog_clear, pslverr,
	input wire logic [15:0] vec_addr, stack_ptr,
	input wire logic [2:0] frame_left
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_sp_push: assert property (push_byte && !pull_byte && !psel
		|=> stack_ptr == $past(stack_ptr) - 16'h0001) else $error("push step wrong");
	a_sp_pull: assert property (pull_byte && !push_byte && !psel
		|=> stack_ptr == $past(stack_ptr) + 16'h0001) else $error("pull step wrong");
	a_sp_hold: assert property (!push_byte && !pull_byte && !psel |=> $stable(stack_ptr))
		else $error("stack pointer moved");
	a_frame_irq: assert property (irq_entry && !push_byte |=> frame_left == 3'h5)
		else $error("entry frame size wrong");
	a_frame_call: assert property (sub_call && !irq_entry && !push_byte |=> frame_left == 3'h2)
		else $error("call frame size wrong");
	a_vec_reset: assert property (reset_vec_req |=> vec_valid && vec_addr == 16'hFFFE)
		else $error("reset vector wrong");
	a_vec_soft: assert property (soft_int_req && !reset_vec_req |=> vec_addr == 16'hFFFC)
		else $error("software vector wrong");
	a_no_reserved: assert property (vec_valid |-> vec_addr != 16'hFFEE)
		else $error("reserved pair granted");
	a_wdog_pulse: assert property (psel && penable && pwrite && paddr == 16'hFFFF
		&& !wdog_clear |=> wdog_clear ##1 !wdog_clear) else $error("watchdog pulse wrong");
	c_entry: cover property (irq_entry);
	c_wdog: cover property (wdog_clear);
	c_err: cover property (pslverr);
endmodule // ivs_chk
bind ivs_vector_stack ivs_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .soft_int_req(soft_int_req),
	.reset_vec_req(reset_vec_req), .irq_entry(irq_entry), .sub_call(sub_call),
	.push_byte(push_byte), .pull_byte(pull_byte), .vec_valid(vec_valid),
	.wdog_clear(wdog_clear), .pslverr(pslverr), .vec_addr(vec_addr),
	.stack_ptr(stack_ptr), .frame_left(frame_left));
`default_nettype wire

// ---- tb/ivs_core_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****
// core stacking model
// ****
module ivs_core_model (
	// clock and commands
	input wire logic pclk, presetn, go_irq, go_call, go_pull,
	// stack operations
	output logic irq_entry, sub_call, push_byte, pull_byte
);
	logic [2:0] owed_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{irq_entry, sub_call, push_byte, pull_byte} <= 4'h0;
			owed_q <= 3'h0;
		end else begin
			irq_entry <= go_irq && owed_q == 3'h0;
			sub_call <= go_call && !go_irq && owed_q == 3'h0;
			pull_byte <= go_pull;
			push_byte <= owed_q != 3'h0;
			// no index high byte in the frame, hence five not six
			if (go_irq && owed_q == 3'h0) owed_q <= 3'h5;
			else if (go_call && owed_q == 3'h0) owed_q <= 3'h2;
			else if (owed_q != 3'h0) owed_q <= owed_q - 3'h1;
		end
	end
endmodule // ivs_core_model
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****
// bench top
// ****
module tb;
	logic pclk, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
	logic soft_int_req = 0, reset_vec_req = 0, go_irq = 0, go_call = 0, go_pull = 0;
	logic irq_entry, sub_call, push_byte, pull_byte, vec_valid, wdog_clear, irq;
	logic [15:0] paddr = 0, vec_addr, stack_ptr;
	logic [31:0] pwdata = 0, prdata, rd, seed = 32'h27134871;
	logic [16:0] src_pending = 0;
	logic [7:0] reset_vec_low = 0;
	logic [4:0] vec_src;
	logic [2:0] frame_left;
	int err_total = 0, num_checks = 0;
	ivs_vector_stack dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .src_pending(src_pending), .soft_int_req(soft_int_req),
		.reset_vec_req(reset_vec_req), .irq_entry(irq_entry), .sub_call(sub_call),
		.push_byte(push_byte), .pull_byte(pull_byte), .reset_vec_low(reset_vec_low),
		.vec_valid(vec_valid), .vec_addr(vec_addr), .vec_src(vec_src),
		.stack_ptr(stack_ptr), .frame_left(frame_left), .wdog_clear(wdog_clear), .irq(irq));
	ivs_core_model core (.pclk(pclk), .presetn(presetn), .go_irq(go_irq), .go_call(go_call),
		.go_pull(go_pull), .irq_entry(irq_entry), .sub_call(sub_call),
		.push_byte(push_byte), .pull_byte(pull_byte));
	initial begin
		pclk = 0;
		forever #12.5 pclk = ~pclk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// lowest source number wins, so scan downwards and keep the last hit
	function automatic logic [16:0] exp_vec(input logic [16:0] s);
		logic [16:0] r;
		r = 17'h0;
		for (int n = 16; n >= 1; n--)
			if (s[n] && n != 7) r = {1'b1, 16'hFFDC + 16'(32 - 2 * n)};
		if (soft_int_req) r = 17'h1FFFC;
		if (reset_vec_req) r = 17'h1FFFE;
		return r;
	endfunction
	function automatic logic [4:0] exp_src(input logic [16:0] s);
		logic [4:0] r;
		r = 5'h0;
		for (int n = 16; n >= 1; n--)
			if (s[n] && n != 7) r = 5'(n);
		if (soft_int_req || reset_vec_req) r = 5'h0;
		return r;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(negedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(negedge pclk);
			n++;
		end
		if (n >= 20) err_total++;
		rd = prdata;
		e = pslverr;
		@(posedge pclk);
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge pclk);
		err_total++;
		complete_run();
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(0, 16'hFE2C, 0);
		chk(rd[15:0], 16'h00FF);
		for (int n = 0; n < 40; n++) begin
			src_pending <= n < 17 ? 17'h1 << n : 17'(rnd());
			soft_int_req <= n > 30 && n[0];
			reset_vec_req <= n == 39;
			apb(1, 16'hFE05, rnd());
			chk({vec_valid, vec_valid ? vec_addr : 16'h0}, exp_vec(src_pending));
			chk(vec_src, exp_src(src_pending));
			apb(0, 16'hFE05, 0);
			chk(rd[7:0], {src_pending[14:8], 1'b0});
			apb(0, 16'hFE06, 0);
			chk(rd[7:0], {6'h0, src_pending[16:15]});
		end
		$display("vector test done");
		reset_vec_low <= 8'(rnd());
		apb(0, 16'hFFFF, 0);
		chk(rd[7:0], reset_vec_low);
		apb(1, 16'hFE28, 1);
		apb(1, 16'hFFFF, rnd());
		chk(irq, 1'b1);
		apb(1, 16'hFE28, 0);
		chk(irq, 1'b0);
		apb(1, 16'hFE28, 1);
		apb(1, 16'hFE24, 1);
		chk(irq, 1'b0);
		apb(0, 16'hFE30, 0);
		chk(e, 1'b1);
		$display("register test done");
		go_irq <= 1;
		@(posedge pclk);
		go_irq <= 0;
		repeat (9) @(posedge pclk);
		chk({frame_left, stack_ptr}, 19'h000FA);
		go_call <= 1;
		@(posedge pclk);
		go_call <= 0;
		repeat (6) @(posedge pclk);
		chk(stack_ptr, 16'h00F8);
		go_pull <= 1;
		repeat (3) @(posedge pclk);
		go_pull <= 0;
		repeat (2) @(posedge pclk);
		chk(stack_ptr, 16'h00FB);
		$display("stack test done");
		complete_run();
	end
endmodule // tb
`default_nettype wire
